// ==== design/alx_pkg.sv ====
// Package of opcodes, widths and field positions for the arithmetic and logic execution block.
package alx_pkg;
   localparam int DATA_W = 8;
   localparam int PTR_W  = 16;
   localparam int LIT6_W = 6;
   localparam int IDX_W  = 7;
   localparam int MSB    = 7;
   localparam int NIB_W  = 4;
   typedef enum logic [2:0] {
      ALX_OP_NONE     = 3'h0,
      ALX_OP_PTR_ADD  = 3'h1,
      ALX_OP_AND_IMM  = 3'h2,
      ALX_OP_ADD_IMM  = 3'h3,
      ALX_OP_AND_MEM  = 3'h4,
      ALX_OP_ADD_MEM  = 3'h5,
      ALX_OP_ASR      = 3'h6,
      ALX_OP_ADD_CIN  = 3'h7
   } alx_op_t;
   localparam logic       DEST_ACC  = 1'h0;
   localparam logic       DEST_MEM  = 1'h1;
   localparam logic [7:0] ACC_RST   = 8'h00;
   localparam logic [15:0] PTR_RST  = 16'h0000;
endpackage : alx_pkg

// ==== design/alx_adder.sv ====
// Eight-bit adder with carry in, carry out of bit 7 and carry out of bit 3.
`timescale 1ns/1ps
`default_nettype none
module alx_adder
   import alx_pkg::*;
(
   input  wire logic [DATA_W-1:0] a,
   input  wire logic [DATA_W-1:0] b,
   input  wire logic              cin,
   output logic      [DATA_W-1:0] sum,
   output logic                   cout,
   output logic                   nib_cout
);
   logic [NIB_W:0]  lo;
   logic [NIB_W:0]  hi;
   always_comb begin
      lo       = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]} + {{NIB_W{1'b0}}, cin};
      hi       = {1'b0, a[DATA_W-1:NIB_W]} + {1'b0, b[DATA_W-1:NIB_W]} + {{NIB_W{1'b0}}, lo[NIB_W]};
      sum      = {hi[NIB_W-1:0], lo[NIB_W-1:0]};
      nib_cout = lo[NIB_W];
      cout     = hi[NIB_W];
   end
endmodule // alx_adder
`default_nettype wire

// ==== design/alx_exec.sv ====
// Execution datapath for the accumulator, flag and pointer-offset instructions.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Pointer add: sign-extended 6-bit literal, flags kept.
// - Pointer sum wraps modulo 65536.
// - AND immediate into accumulator, zero flag only.
// - Add immediate into accumulator, sets carry, nibble, zero.
// - AND memory, destination bit selects, Z only.
// - Add memory, destination bit selects, carry nibble zero.
// - Shift right keeping bit 7, bit0 to C.
// - Add with carry in, destination selected, three flags.
module alx_exec
   import alx_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              srst,
   input  wire logic              op_valid,
   input  wire alx_op_t           op_code,
   input  wire logic [DATA_W-1:0] op_literal,
   input  wire logic [LIT6_W-1:0] op_ptr_literal,
   input  wire logic              op_ptr_sel,
   input  wire logic              op_dest,
   input  wire logic [IDX_W-1:0]  op_mem_index,
   input  wire logic [DATA_W-1:0] mem_operand,
   input  wire logic [PTR_W-1:0]  ptr0_in,
   input  wire logic [PTR_W-1:0]  ptr1_in,
   input  wire logic [DATA_W-1:0] acc_in,
   input  wire logic              carry_in,
   output logic      [DATA_W-1:0] acc_q,
   output logic                   acc_we_q,
   output logic      [DATA_W-1:0] mem_wdata_q,
   output logic      [IDX_W-1:0]  mem_index_q,
   output logic                   mem_we_q,
   output logic      [PTR_W-1:0]  ptr_q,
   output logic                   ptr_sel_q,
   output logic                   ptr_we_q,
   output logic                   flag_c_q,
   output logic                   flag_low_nibble_out_q,
   output logic                   flag_z_q,
   output logic                   flags_we_q
);
   ////////////////////////////////////////////////////////////////////////////////
   // Flags are written back whole; an untouched carry passes carry_in through, untouched nibble and zero keep their registered value.
   function automatic logic is_zero(input logic [DATA_W-1:0] v);
      return v == {DATA_W{1'b0}};
   endfunction

   logic [DATA_W-1:0] add_b;
   logic              add_cin;
   logic [DATA_W-1:0] add_sum;
   logic              add_c;
   logic              add_low_nibble_out;

   always_comb begin
      add_b   = (op_code == ALX_OP_ADD_IMM) ? op_literal : mem_operand;
      add_cin = (op_code == ALX_OP_ADD_CIN) ? carry_in : 1'b0;
   end

   alx_adder u_add (
      .a        (acc_in),
      .b        (add_b),
      .cin      (add_cin),
      .sum      (add_sum),
      .cout     (add_c),
      .nib_cout (add_low_nibble_out)
   );

   logic [DATA_W-1:0] acc_d;
   logic              acc_we_d;
   logic [DATA_W-1:0] mem_wdata_d;
   logic [IDX_W-1:0]  mem_index_d;
   logic              mem_we_d;
   logic [PTR_W-1:0]  ptr_d;
   logic              ptr_sel_d;
   logic              ptr_we_d;
   logic              c_d;
   logic              low_nibble_out_d;
   logic              z_d;
   logic              flags_we_d;
   logic [DATA_W-1:0] res;
   logic              to_mem;
   logic [PTR_W-1:0]  ptr_src;

   always_comb begin
      res         = acc_in;
      to_mem      = 1'b0;
      acc_d       = acc_q;
      acc_we_d    = 1'b0;
      mem_wdata_d = mem_wdata_q;
      mem_index_d = op_mem_index;
      mem_we_d    = 1'b0;
      ptr_src     = op_ptr_sel ? ptr1_in : ptr0_in;
      ptr_d       = ptr_q;
      ptr_sel_d   = op_ptr_sel;
      ptr_we_d    = 1'b0;
      c_d         = carry_in;
      low_nibble_out_d = flag_low_nibble_out_q;
      z_d         = flag_z_q;
      flags_we_d  = 1'b0;
      if (op_valid) begin
         case (op_code)
            ALX_OP_PTR_ADD: begin
               // Sixteen-bit add drops the carry out, so the pointer wraps both ways.
               ptr_d    = ptr_src + {{(PTR_W-LIT6_W){op_ptr_literal[LIT6_W-1]}}, op_ptr_literal};
               ptr_we_d = 1'b1;
            end
            ALX_OP_AND_IMM: begin
               res = acc_in & op_literal;
               z_d = is_zero(res);
               low_nibble_out_d = flag_low_nibble_out_q;
               flags_we_d = 1'b1;
            end
            ALX_OP_AND_MEM: begin
               res    = acc_in & mem_operand;
               to_mem = (op_dest == DEST_MEM);
               z_d    = is_zero(res);
               flags_we_d = 1'b1;
            end
            ALX_OP_ADD_IMM, ALX_OP_ADD_MEM, ALX_OP_ADD_CIN: begin
               res    = add_sum;
               to_mem = (op_code != ALX_OP_ADD_IMM) && (op_dest == DEST_MEM);
               c_d    = add_c;
               low_nibble_out_d = add_low_nibble_out;
               z_d    = is_zero(res);
               flags_we_d = 1'b1;
            end
            ALX_OP_ASR: begin
               res    = {mem_operand[MSB], mem_operand[MSB:1]};
               to_mem = (op_dest == DEST_MEM);
               c_d    = mem_operand[0];
               z_d    = is_zero(res);
               flags_we_d = 1'b1;
            end
            default: begin
               flags_we_d = 1'b0;
            end
         endcase
         if (op_code != ALX_OP_PTR_ADD && op_code != ALX_OP_NONE) begin
            if (to_mem) begin
               mem_wdata_d = res;
               mem_we_d    = 1'b1;
            end else begin
               acc_d    = res;
               acc_we_d = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         acc_q       <= ACC_RST;
         acc_we_q    <= 1'b0;
         mem_wdata_q <= ACC_RST;
         mem_index_q <= '0;
         mem_we_q    <= 1'b0;
         ptr_q       <= PTR_RST;
         ptr_sel_q   <= 1'b0;
         ptr_we_q    <= 1'b0;
         flag_c_q    <= 1'b0;
         flag_low_nibble_out_q <= 1'b0;
         flag_z_q    <= 1'b0;
         flags_we_q  <= 1'b0;
      end else begin
         acc_q       <= acc_d;
         acc_we_q    <= acc_we_d;
         mem_wdata_q <= mem_wdata_d;
         mem_index_q <= mem_index_d;
         mem_we_q    <= mem_we_d;
         ptr_q       <= ptr_d;
         ptr_sel_q   <= ptr_sel_d;
         ptr_we_q    <= ptr_we_d;
         flag_c_q    <= c_d;
         flag_low_nibble_out_q <= low_nibble_out_d;
         flag_z_q    <= z_d;
         flags_we_q  <= flags_we_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_ptr_flags;
      @(posedge clk_sys) disable iff (srst)
      (op_valid && op_code == ALX_OP_PTR_ADD) |=> (!flags_we_q && ptr_we_q && !acc_we_q && !mem_we_q
         && flag_c_q == $past(carry_in) && flag_low_nibble_out_q == $past(flag_low_nibble_out_q)
         && flag_z_q == $past(flag_z_q));
   endproperty
   a_ptr_flags: assert property (p_ptr_flags) else $error("pointer add touched flags");

   property p_ptr_sum;
      @(posedge clk_sys) disable iff (srst)
      (op_valid && op_code == ALX_OP_PTR_ADD) |=>
         ptr_q == 16'($past(ptr_src) + {{(PTR_W-LIT6_W){$past(op_ptr_literal[LIT6_W-1])}}, $past(op_ptr_literal)});
   endproperty
   a_ptr_sum: assert property (p_ptr_sum) else $error("pointer sum wrong");

   property p_and_imm;
      @(posedge clk_sys) disable iff (srst)
      (op_valid && op_code == ALX_OP_AND_IMM) |=>
         (acc_we_q && acc_q == ($past(acc_in) & $past(op_literal)) && flag_c_q == $past(carry_in)
          && flag_low_nibble_out_q == $past(flag_low_nibble_out_q));
   endproperty
   a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

   property p_add_imm;
      @(posedge clk_sys) disable iff (srst)
      (op_valid && op_code == ALX_OP_ADD_IMM) |=>
         ({flag_c_q, acc_q} == {1'b0, $past(acc_in)} + {1'b0, $past(op_literal)}) && acc_we_q;
   endproperty
   a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");

   property p_and_mem_dest;
      @(posedge clk_sys) disable iff (srst)
      (op_valid && op_code == ALX_OP_AND_MEM && op_dest == DEST_MEM) |=>
         (mem_we_q && !acc_we_q && mem_wdata_q == ($past(acc_in) & $past(mem_operand)));
   endproperty
   a_and_mem_dest: assert property (p_and_mem_dest) else $error("and memory destination wrong");

   property p_add_mem;
      @(posedge clk_sys) disable iff (srst)
      (op_valid && op_code == ALX_OP_ADD_MEM && op_dest == DEST_ACC) |=>
         (acc_we_q && !mem_we_q && acc_q == 8'($past(acc_in) + $past(mem_operand)));
   endproperty
   a_add_mem: assert property (p_add_mem) else $error("add memory wrong");

   property p_asr;
      @(posedge clk_sys) disable iff (srst)
      (op_valid && op_code == ALX_OP_ASR) |=>
         (flag_c_q == $past(mem_operand[0]) && flag_low_nibble_out_q == $past(flag_low_nibble_out_q)
          && (mem_we_q ? mem_wdata_q : acc_q) == {$past(mem_operand[MSB]), $past(mem_operand[MSB:1])});
   endproperty
   a_asr: assert property (p_asr) else $error("shift right wrong");

   property p_add_cin;
      @(posedge clk_sys) disable iff (srst)
      (op_valid && op_code == ALX_OP_ADD_CIN && op_dest == DEST_MEM) |=>
         ({flag_c_q, mem_wdata_q} == {1'b0, $past(acc_in)} + {1'b0, $past(mem_operand)} + 9'($past(carry_in)));
   endproperty
   a_add_cin: assert property (p_add_cin) else $error("add with carry wrong");

   property p_zero;
      @(posedge clk_sys) disable iff (srst)
      flags_we_q |-> (flag_z_q == ((mem_we_q ? mem_wdata_q : acc_q) == 8'h00));
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule // alx_exec
`default_nettype wire

// ==== bench/alx_core_model.sv ====
// Behavioural model of the decoder side: accumulator, carry, pointer pair and data memory.
`timescale 1ns/1ps
`default_nettype none
module alx_core_model
   import alx_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              srst,
   input  wire logic [IDX_W-1:0]  op_mem_index,
   input  wire logic [DATA_W-1:0] acc_q,
   input  wire logic              acc_we_q,
   input  wire logic [DATA_W-1:0] mem_wdata_q,
   input  wire logic [IDX_W-1:0]  mem_index_q,
   input  wire logic              mem_we_q,
   input  wire logic [PTR_W-1:0]  ptr_q,
   input  wire logic              ptr_sel_q,
   input  wire logic              ptr_we_q,
   input  wire logic              flag_c_q,
   input  wire logic              flags_we_q,
   output logic      [DATA_W-1:0] mem_operand,
   output logic      [PTR_W-1:0]  ptr0_in,
   output logic      [PTR_W-1:0]  ptr1_in,
   output logic      [DATA_W-1:0] acc_in,
   output logic                   carry_in
);
   logic [DATA_W-1:0] mem [128];
   assign mem_operand = mem[op_mem_index];
   // Results commit one edge after they appear, as a real register file would.
   always @(posedge clk_sys) begin
      if (srst) begin
         acc_in <= 8'h00;
         carry_in <= 1'b0;
         ptr0_in <= 16'h0000;
         ptr1_in <= 16'hFFF0;
         for (int i = 0; i < 128; i++) mem[i] <= 8'(i * 8'h25);
      end else begin
         if (acc_we_q) acc_in <= acc_q;
         if (mem_we_q) mem[mem_index_q] <= mem_wdata_q;
         if (flags_we_q) carry_in <= flag_c_q;
         if (ptr_we_q && ptr_sel_q) ptr1_in <= ptr_q;
         if (ptr_we_q && !ptr_sel_q) ptr0_in <= ptr_q;
      end
   end
endmodule // alx_core_model
`default_nettype wire

// ==== bench/arith_logic_instr_exec_bench.sv ====
// Self-checking bench for the arithmetic and logic execution block.
`timescale 1ns/1ps
`default_nettype none
module arith_logic_instr_exec_bench;
   import alx_pkg::*;
   logic        clk_sys, srst, op_valid, op_ptr_sel, op_dest, carry_in, acc_we_q, mem_we_q, ptr_we_q, ptr_sel_q;
   logic        flag_c_q, flag_low_nibble_out_q, flag_z_q, flags_we_q, p_take, p_dest, p_sel, e_c, e_nib, h_nib, h_z;
   alx_op_t     op_code, p_op;
   logic [7:0]  op_literal, mem_operand, acc_in, acc_q, mem_wdata_q, e_r;
   logic [5:0]  op_ptr_literal;
   logic [6:0]  op_mem_index, mem_index_q, p_idx;
   logic [15:0] ptr0_in, ptr1_in, ptr_q, e_ptr;
   int          fails, check_count;
   alx_exec dut_u (.clk_sys(clk_sys), .srst(srst), .op_valid(op_valid), .op_code(op_code),
      .op_literal(op_literal), .op_ptr_literal(op_ptr_literal), .op_ptr_sel(op_ptr_sel), .op_dest(op_dest),
      .op_mem_index(op_mem_index), .mem_operand(mem_operand), .ptr0_in(ptr0_in), .ptr1_in(ptr1_in),
      .acc_in(acc_in), .carry_in(carry_in), .acc_q(acc_q), .acc_we_q(acc_we_q), .mem_wdata_q(mem_wdata_q),
      .mem_index_q(mem_index_q), .mem_we_q(mem_we_q), .ptr_q(ptr_q), .ptr_sel_q(ptr_sel_q), .ptr_we_q(ptr_we_q),
      .flag_c_q(flag_c_q), .flag_low_nibble_out_q(flag_low_nibble_out_q), .flag_z_q(flag_z_q),
      .flags_we_q(flags_we_q));
   alx_core_model core_u (.clk_sys(clk_sys), .srst(srst), .op_mem_index(op_mem_index), .acc_q(acc_q),
      .acc_we_q(acc_we_q), .mem_wdata_q(mem_wdata_q), .mem_index_q(mem_index_q), .mem_we_q(mem_we_q),
      .ptr_q(ptr_q), .ptr_sel_q(ptr_sel_q), .ptr_we_q(ptr_we_q), .flag_c_q(flag_c_q),
      .flags_we_q(flags_we_q), .mem_operand(mem_operand), .ptr0_in(ptr0_in), .ptr1_in(ptr1_in),
      .acc_in(acc_in), .carry_in(carry_in));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_val(string n, logic [15:0] s, logic [15:0] e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chk_bit(string n, logic s, logic e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %b seen %b", n, e, s);
      end
   endtask
   // Every output must read zero after reset, and the held flags restart from zero.
   task automatic chk_reset();
      chk_val("acc after reset", 16'(acc_q), 16'h0000);
      chk_val("mem data after reset", 16'(mem_wdata_q), 16'h0000);
      chk_val("index after reset", 16'(mem_index_q), 16'h0000);
      chk_val("pointer after reset", ptr_q, 16'h0000);
      chk_val("outputs after reset", 16'({acc_we_q, mem_we_q, ptr_we_q, ptr_sel_q, flags_we_q, flag_c_q,
         flag_low_nibble_out_q, flag_z_q}), 16'h0000);
      h_nib = 1'b0;
      h_z = 1'b0;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Compares what the op issued one edge earlier left at the outputs.
   // The nibble and zero flags are held between ops, so the bench tracks their last values.
   task automatic check_prev();
      logic [3:0] we;
      logic       adds;
      we = 4'h0;
      adds = p_op inside {ALX_OP_ADD_IMM, ALX_OP_ADD_MEM, ALX_OP_ADD_CIN};
      if (p_take) we = (p_op == ALX_OP_PTR_ADD) ? 4'h2 : (p_dest ? 4'h5 : 4'h9);
      chk_val("enables", 16'({acc_we_q, mem_we_q, ptr_we_q, flags_we_q}), 16'(we));
      if (p_take && p_op == ALX_OP_PTR_ADD) begin
         chk_val("pointer", ptr_q, e_ptr);
         chk_bit("ptr_sel", ptr_sel_q, p_sel);
         chk_bit("carry kept", flag_c_q, e_c);
         chk_bit("zero kept", flag_z_q, h_z);
         chk_bit("nibble kept", flag_low_nibble_out_q, h_nib);
      end else if (p_take) begin
         chk_val("result", 16'(p_dest ? mem_wdata_q : acc_q), 16'(e_r));
         if (p_dest) chk_val("index", 16'(mem_index_q), 16'(p_idx));
         chk_bit("zero", flag_z_q, e_r == 8'h00);
         chk_bit("carry", flag_c_q, e_c);
         if (adds) chk_bit("nibble", flag_low_nibble_out_q, e_nib);
         else chk_bit("nibble kept", flag_low_nibble_out_q, h_nib);
         h_z = (e_r == 8'h00);
         if (adds) h_nib = e_nib;
      end
   endtask
   // Drives one request and works out what it must produce.
   task automatic issue(logic v, alx_op_t c, logic [7:0] k, logic [5:0] pk, logic s, logic d, logic [6:0] ix);
      logic [8:0] sum;
      logic [4:0] nib;
      logic [7:0] b;
      logic       ci, im;
      op_valid = v;
      op_code = c;
      op_literal = k;
      op_ptr_literal = pk;
      op_ptr_sel = s;
      op_dest = d;
      op_mem_index = ix;
      #1;
      im = c inside {ALX_OP_ADD_IMM, ALX_OP_AND_IMM};
      b = im ? k : mem_operand;
      ci = (c == ALX_OP_ADD_CIN) ? carry_in : 1'b0;
      sum = {1'b0, acc_in} + {1'b0, b} + 9'(ci);
      nib = {1'b0, acc_in[3:0]} + {1'b0, b[3:0]} + 5'(ci);
      e_nib = nib[4];
      e_c = sum[8];
      e_r = sum[7:0];
      if (c inside {ALX_OP_AND_IMM, ALX_OP_AND_MEM}) begin
         e_r = acc_in & b;
         e_c = carry_in;
      end
      if (c == ALX_OP_ASR) begin
         e_r = {b[7], b[7:1]};
         e_c = b[0];
      end
      if (c == ALX_OP_PTR_ADD) e_c = carry_in;
      e_ptr = (s ? ptr1_in : ptr0_in) + {{10{pk[5]}}, pk};
      p_take = v && c != ALX_OP_NONE;
      p_op = c;
      p_dest = d && !im;
      p_sel = s;
      p_idx = ix;
   endtask
   task automatic step(logic v, alx_op_t c, logic [7:0] k, logic [5:0] pk, logic s, logic d, logic [6:0] ix);
      check_prev();
      issue(v, c, k, pk, s, d, ix);
      @(negedge clk_sys);
      // An idle slot lets the model commit, so the next corner sees the new state.
      check_prev();
      issue(1'b0, ALX_OP_NONE, 8'h00, 6'h00, 1'b0, 1'b0, 7'h00);
      @(negedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      #(20000 * 50);
      fails++;
      print_verdict();
   end
   initial begin
      fails = 0;
      check_count = 0;
      void'($urandom(56));
      srst = 1'b1;
      issue(1'b0, ALX_OP_NONE, 8'h00, 6'h00, 1'b0, 1'b0, 7'h00);
      p_take = 1'b0;
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      srst = 1'b0;
      chk_reset();
      step(1'b1, ALX_OP_AND_IMM, 8'h00, 6'h00, 1'b0, 1'b1, 7'h00);
      step(1'b1, ALX_OP_ADD_IMM, 8'hF0, 6'h00, 1'b0, 1'b0, 7'h00);
      step(1'b1, ALX_OP_ADD_IMM, 8'h20, 6'h00, 1'b0, 1'b0, 7'h00);
      step(1'b1, ALX_OP_ADD_CIN, 8'h00, 6'h00, 1'b0, 1'b1, 7'h7F);
      step(1'b1, ALX_OP_ASR, 8'h00, 6'h00, 1'b0, 1'b1, 7'h05);
      step(1'b1, ALX_OP_AND_MEM, 8'h00, 6'h00, 1'b0, 1'b0, 7'h05);
      step(1'b1, ALX_OP_ADD_MEM, 8'h00, 6'h00, 1'b0, 1'b1, 7'h01);
      step(1'b1, ALX_OP_PTR_ADD, 8'h00, 6'h3F, 1'b0, 1'b0, 7'h00);
      step(1'b1, ALX_OP_PTR_ADD, 8'h00, 6'h01, 1'b0, 1'b0, 7'h00);
      step(1'b1, ALX_OP_PTR_ADD, 8'h00, 6'h1F, 1'b1, 1'b0, 7'h00);
      step(1'b1, ALX_OP_PTR_ADD, 8'h00, 6'h20, 1'b1, 1'b0, 7'h00);
      step(1'b1, ALX_OP_NONE, 8'hFF, 6'h00, 1'b0, 1'b1, 7'h00);
      step(1'b0, ALX_OP_ADD_IMM, 8'hFF, 6'h00, 1'b0, 1'b1, 7'h00);
      // Random back-to-back traffic, every code and destination.
      repeat (600) begin
         check_prev();
         issue(($urandom % 8) != 0, alx_op_t'($urandom % 8), 8'($urandom), 6'($urandom), 1'($urandom),
            1'($urandom), 7'($urandom));
         @(negedge clk_sys);
      end
      check_prev();
      // A reset in mid-run must clear every output and restart the model's state.
      srst = 1'b1;
      issue(1'b0, ALX_OP_NONE, 8'h00, 6'h00, 1'b0, 1'b0, 7'h00);
      repeat (2) @(negedge clk_sys);
      srst = 1'b0;
      chk_reset();
      step(1'b1, ALX_OP_ADD_MEM, 8'h00, 6'h00, 1'b0, 1'b0, 7'h03);
      step(1'b1, ALX_OP_ADD_CIN, 8'h00, 6'h00, 1'b0, 1'b0, 7'h7E);
      check_prev();
      print_verdict();
   end
endmodule // arith_logic_instr_exec_bench
`default_nettype wire
